// ===== bench/tb.sv
`default_nettype none
`define CHK(g, e) \
   begin \
      num_checks++; \
      if ((g) !== (e)) \
      begin \
         failures++; \
         $display("MISMATCH at %0t: got %h exp %h", $time, (g), (e)); \
      end \
   end
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int NCH = 4;
   logic i_clk, i_resetn, i_req, i_halt, o_ack, o_halt;
   tmb_pkg::tmb_host_req_type i_host;
   logic [NCH-1:0] i_cap_pin, o_irq_req;
   logic [31:0] o_rdata;
   logic [63:0] o_lanes;
   logic [63:0] j_lanes;
   logic [31:0] seed = 32'h5c0b;
   int failures = 0;
   int num_checks = 0;
   int cycles = 0;
   int mem[64];
   int armed[NCH];
   int rs[5] = '{1, 2, 3, 20, 63};
   tmb_bridge #(.NUM_CH(NCH), .SPLIT_M(3), .JOIN_LANES(1'b0)) u_dut
   (
      .i_clk(i_clk), .i_resetn(i_resetn), .i_req(i_req),
      .i_host(i_host), .i_halt(i_halt), .i_cap_pin(i_cap_pin),
      .o_ack(o_ack), .o_rdata(o_rdata), .o_halt(o_halt),
      .o_irq_req(o_irq_req), .o_lanes(o_lanes)
   );
   // same traffic, lanes joined at build time
   tmb_bridge #(.NUM_CH(NCH), .SPLIT_M(3), .JOIN_LANES(1'b1)) u_dut_join
   (
      .i_clk(i_clk), .i_resetn(i_resetn), .i_req(i_req),
      .i_host(i_host), .i_halt(i_halt), .i_cap_pin(i_cap_pin),
      .o_ack(), .o_rdata(), .o_halt(),
      .o_irq_req(), .o_lanes(j_lanes)
   );
   tmb_host_model u_host
   (
      .i_clk(i_clk), .i_ack(o_ack), .i_rdata(o_rdata),
      .o_req(i_req), .o_host(i_host)
   );
   initial
   begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end
   task automatic finish_test();
      if (failures == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : finish_test
   always @(posedge i_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         failures++;
         finish_test();
      end
   end
   function automatic logic [31:0] rnd();
      seed = seed[0] ? (seed >> 1) ^ 32'h80200003 : seed >> 1;
      return seed;
   endfunction : rnd
   // ---------------------------------------------------------------
   // reference register model
   // ---------------------------------------------------------------
   function automatic int msk(int i);
      if (i == 0) return 32'h1;
      if (i == 4 || i == 6) return 32'hffff;
      if (i == 5 || i == 7) return 32'h3;
      if (i >= 8 && i < 8 + 2 * NCH && i % 2 == 0) return 32'h7;
      return 0;
   endfunction : msk
   function automatic void put(int i, int d, int be);
      int m;
      m = msk(i) & (((be & 2) ? 32'hff00 : 0) | ((be & 1) ? 32'hff : 0));
      if (msk(i) == 7)
      begin
         if ((be & 2) && !(d & 32'h8000) && armed[(i - 8) / 2])
            mem[i] &= 32'h7fff;
         armed[(i - 8) / 2] = 0;
      end
      mem[i] = (mem[i] & ~m) | (d & m);
   endfunction : put
   function automatic int get(int i);
      if (msk(i) == 7 && mem[i] >= 32'h8000)
         armed[(i - 8) / 2] = 1;
      return mem[i];
   endfunction : get
   function automatic logic [31:0] ref_acc(logic wr, int sz, int a, int wd);
      int i;
      i = a / 2;
      if (a % 2 == 1 || sz == 0)
      begin
         if (wr)
            put(i, (wd & 32'hff) << ((a % 2) ? 0 : 8), (a % 2) ? 1 : 2);
         else
            return (get(i) >> ((a % 2) ? 0 : 8)) & 32'hff;
      end
      else if (sz == 3)
      begin
         if (wr)
         begin
            put(i, (wd >> 16) & 32'hffff, 3);
            put(i + 1, wd & 32'hffff, 3);
         end
         else
            return (get(i) << 16) | get(i + 1);
      end
      else if (wr)
         put(i, wd & 32'hffff, 3);
      else
         return get(i);
      return 0;
   endfunction : ref_acc
   // ---------------------------------------------------------------
   // access helpers
   // ---------------------------------------------------------------
   task automatic acc(logic wr, int sz, int a, logic [31:0] wd);
      logic [31:0] rd;
      logic [31:0] ex;
      int lat;
      u_host.xfer(wr, tmb_pkg::tmb_size_type'(sz), a[6:0], wd, rd, lat);
      ex = ref_acc(wr, sz, a, wd);
      `CHK(lat, (sz == 3 && a % 2 == 0) ? 3 : 2);
      if (!wr)
         `CHK(rd, ex);
   endtask : acc
   task automatic mis_long(int a, logic [31:0] d);
      acc(1, 0, a, d >> 24);
      acc(1, 2, a + 1, (d >> 8) & 32'hffff);
      acc(1, 0, a + 3, d & 32'hff);
   endtask : mis_long
   // capture pin 0 moves; hit says whether the edge is the selected one
   task automatic pin(logic lv, logic hit);
      @(posedge i_clk);
      #1;
      i_cap_pin[0] = lv;
      repeat (8) @(posedge i_clk);
      #1;
      if (hit)
      begin
         mem[9] = mem[4];
         mem[8] |= 32'h8000;
         armed[0] = 0;
      end
      `CHK(o_irq_req[0], mem[8][15] & mem[8][2]);
      acc(0, 1, 18, 0);
   endtask : pin
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial
   begin
      int a;
      int ln;
      logic [31:0] v;
      logic [63:0] e;
      logic [15:0] ja;
      logic [15:0] jb;
      i_resetn = 1'b0;
      i_halt = 1'b0;
      i_cap_pin = '0;
      foreach (mem[k]) mem[k] = 0;
      foreach (armed[k]) armed[k] = 0;
      repeat (4) @(posedge i_clk);
      #1;
      `CHK({o_ack, o_halt, o_irq_req, o_rdata, o_lanes, j_lanes}, '0);
      i_resetn = 1'b1;
      // halt forwarded keeps counters frozen, so lane values stay exact
      i_halt = 1'b1;
      acc(1, 1, 0, 32'h0);
      @(posedge i_clk);
      #1;
      `CHK(o_halt, 1'b0);
      acc(1, 1, 0, 32'hffff);
      @(posedge i_clk);
      #1;
      `CHK(o_halt, 1'b1);
      foreach (rs[k])
      begin
         acc(1, 1, 2 * rs[k], rnd());
         acc(0, 1, 2 * rs[k], 0);
      end
      for (int k = 0; k < 32; k++)
      begin
         a = 8 + 2 * (rnd() % 4) + (k / 4) % 2;
         acc(1, k % 4, a, rnd());
         acc(0, k % 4, a, 0);
         acc(0, 3, 8, 0);
         acc(0, 3, 12, 0);
      end
      acc(1, 0, 9, rnd());
      acc(1, 0, 10, rnd());
      mis_long(9, rnd());
      acc(0, 3, 8, 0);
      acc(0, 3, 12, 0);
      for (int k = 0; k < 4; k++)
      begin
         v = rnd() & 32'hffff;
         acc(1, 3, 8, (v << 16) | ((k < 2) ? 1 + 2 * k : 0));
         acc(1, 3, 12, ((~v & 32'hffff) << 16) | ((k >= 2) ? 2 * k - 3 : 0));
         // a disabled counter still drives its selected lane
         ln = (k == 1) ? 3 : 2;
         e = (64'(v) << (16 * ln))
            | (64'(~v & 32'hffff) << (16 * ((k == 3) ? 1 : 0)));
         `CHK(o_lanes, e);
         ja = e[15:0] | e[63:48];
         jb = e[31:16] | e[47:32];
         `CHK(j_lanes, {ja, jb, jb, ja});
      end
      acc(1, 3, 8, (rnd() << 16) | 32'h1);
      acc(1, 3, 12, 32'h0);
      acc(1, 1, 16, 32'h5);
      pin(1'b1, 1'b1);
      acc(1, 1, 8, rnd());
      pin(1'b0, 1'b0);
      pin(1'b1, 1'b1);
      acc(1, 1, 16, 32'h8005);
      acc(0, 1, 16, 0);
      pin(1'b0, 1'b0);
      pin(1'b1, 1'b1);
      acc(1, 1, 16, 32'h5);
      acc(0, 1, 16, 0);
      acc(1, 1, 16, 32'h5);
      acc(0, 1, 16, 0);
      acc(1, 1, 16, 32'h4);
      pin(1'b0, 1'b1);
      pin(1'b1, 1'b0);
      // release halt for ten edges; counter 0 is enabled
      i_halt = 1'b0;
      repeat (10) @(posedge i_clk);
      #1;
      i_halt = 1'b1;
      mem[4] = (mem[4] + 10) & 32'hffff;
      acc(0, 1, 8, 0);
      finish_test();
   end
endmodule : tb
`default_nettype wire

// ===== bench/tmb_host_model.sv
`default_nettype none
module tmb_host_model
(
   input wire logic i_clk,
   input wire logic i_ack,
   input wire logic [31:0] i_rdata,
   output logic o_req,
   output var tmb_pkg::tmb_host_req_type o_host
);
   timeunit 1ns;
   timeprecision 100ps;
   initial
   begin
      o_req = 1'b0;
      o_host = '0;
   end
   // ---------------------------------------------------------------
   // one host transfer
   // ---------------------------------------------------------------
   // request only for the taking cycle, else a second access is taken
   task automatic xfer(input logic wr, input tmb_pkg::tmb_size_type sz,
      input logic [6:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output int lat);
      @(posedge i_clk);
      #1;
      o_req = 1'b1;
      o_host = {wr, sz, a, wd};
      @(posedge i_clk);
      #1;
      o_req = 1'b0;
      // latency counted from the taking edge
      lat = 1;
      while (i_ack !== 1'b1 && lat < 8)
      begin
         @(posedge i_clk);
         #1;
         lat++;
      end
      rd = i_rdata;
      // idle bus carries junk so a stale request never looks valid
      o_host = ~o_host;
   endtask : xfer
endmodule : tmb_host_model
`default_nettype wire

// ===== rtl/tmb_bridge.sv
// Function
// - registers and internal paths are 16 bits; words are the normal size
// - bytes and long words accepted; no coherency across byte accesses
// - aligned word access reads or writes 16 bits in one operation
// - word at odd address performs only one byte access there
// - aligned long is two words; long indication during high-order word
// - three-byte transfer handled as one aligned word only
// - four 16-bit lanes; each channel attaches to exactly two
// - low-numbered channels use lanes three/four, others lanes one/two
// - design option joins lanes one/four and two/three
// - lanes resolve multiple drivers by wired-OR
// - channels either drive lanes or read them
// - bridge plus at least one counter source always present
// - all channel traffic uses the single internal submodule bus
// - selected edge captures counter, sets flag, requests irq if enabled
// - later capture overwrites unread earlier stamp
// - flag clears by read then write zero; new event keeps it set
// - halt forwarded to channels only when pass-through bit is one
// - unused bits and reserved addresses read zero, ignore writes
`default_nettype none
module tmb_bridge
#(
   parameter int NUM_CH = 4,
   parameter int SPLIT_M = 3,
   parameter bit JOIN_LANES = 1'b0
)
(
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_req,
   input wire tmb_pkg::tmb_host_req_type i_host,
   input wire logic i_halt,
   input wire logic [NUM_CH-1:0] i_cap_pin,
   output logic o_ack,
   output logic [31:0] o_rdata,
   output logic o_halt,
   output logic [NUM_CH-1:0] o_irq_req,
   output logic [tmb_pkg::DATA_W*tmb_pkg::NUM_LANES-1:0] o_lanes
);
   localparam int W = tmb_pkg::DATA_W;

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   function automatic logic [W-1:0] merge(input logic [W-1:0] old,
      input logic [W-1:0] wd, input logic [1:0] be);
      logic [W-1:0] m;
      m = {{8{be[1]}}, {8{be[0]}}};
      merge = (old & ~m) | (wd & m);
   endfunction : merge

   // -----------------------------------------------------------------
   // bridge sequencer
   // -----------------------------------------------------------------
   tmb_pkg::tmb_state_type state_q;
   tmb_pkg::tmb_host_req_type req_q;
   tmb_pkg::tmb_sm_bus_type sm;
   logic take;
   logic is_byte;
   logic is_long;

   assign take = i_req && (state_q == tmb_pkg::ST_IDLE);
   // odd address always collapses to the one byte there
   assign is_byte = (req_q.size == tmb_pkg::SZ_BYTE) || req_q.addr[0];
   // a triple is only its aligned word; master finishes the byte
   assign is_long = (req_q.size == tmb_pkg::SZ_LONG) && !is_byte;
   assign o_ack = (state_q == tmb_pkg::ST_DONE);

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         state_q <= tmb_pkg::ST_IDLE;
      else
         unique case (state_q)
            tmb_pkg::ST_IDLE: if (i_req) state_q <= tmb_pkg::ST_HIGH;
            tmb_pkg::ST_HIGH: state_q <= is_long ? tmb_pkg::ST_LOW
               : tmb_pkg::ST_DONE;
            tmb_pkg::ST_LOW: state_q <= tmb_pkg::ST_DONE;
            tmb_pkg::ST_DONE: state_q <= tmb_pkg::ST_IDLE;
         endcase
   end

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         req_q <= '0;
      else if (take)
         req_q <= i_host;
   end

   // single internal bus; no pipelining so no cross-access coherency
   always_comb
   begin
      sm.act = (state_q == tmb_pkg::ST_HIGH) || (state_q == tmb_pkg::ST_LOW);
      sm.wr = req_q.wr;
      sm.long_ind = is_long && (state_q == tmb_pkg::ST_HIGH);
      sm.idx = req_q.addr[tmb_pkg::ADDR_W-1:1]
         + ((state_q == tmb_pkg::ST_LOW) ? 6'h01 : 6'h00);
      sm.be = is_byte ? (req_q.addr[0] ? 2'h1 : 2'h2) : 2'h3;
      if (is_byte)
         sm.wdata = {req_q.wdata[7:0], req_q.wdata[7:0]};
      else if (sm.long_ind)
         sm.wdata = req_q.wdata[31:16];
      else
         sm.wdata = req_q.wdata[15:0];
   end

   // -----------------------------------------------------------------
   // registers on the submodule bus
   // -----------------------------------------------------------------
   logic [W-1:0] mcr_q;
   logic [W-1:0] cnt_q [2];
   logic [W-1:0] cnt_ctl_q [2];
   logic [W-1:0] ch_ctl_q [NUM_CH];
   logic [W-1:0] cap_val [NUM_CH];
   logic [NUM_CH-1:0] cap_evt;
   logic [NUM_CH-1:0] armed_q;
   logic [W-1:0] rd_word;
   logic [W-1:0] lane [tmb_pkg::NUM_LANES];
   logic [W-1:0] lane_or [tmb_pkg::NUM_LANES];
   logic sm_wr;
   logic sm_rd;

   assign sm_wr = sm.act && sm.wr;
   assign sm_rd = sm.act && !sm.wr;

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         mcr_q <= tmb_pkg::RST_WORD;
      else if (sm_wr && sm.idx == tmb_pkg::IDX_MCR)
         mcr_q <= merge(mcr_q, sm.wdata, sm.be) & 16'h0001;
   end

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         o_halt <= 1'b0;
      else
         o_halt <= i_halt && mcr_q[tmb_pkg::MCR_HALT_PASS];
   end

   // two counter sources, one on each side of the lane split
   for (genvar k = 0; k < 2; k++)
   begin : g_cnt
      localparam logic [5:0] IV = tmb_pkg::IDX_CNT_BASE + 6'(2*k);
      always_ff @(posedge i_clk or negedge i_resetn)
      begin
         if (!i_resetn)
            cnt_q[k] <= tmb_pkg::RST_WORD;
         else if (sm_wr && sm.idx == IV)
            cnt_q[k] <= merge(cnt_q[k], sm.wdata, sm.be);
         else if (cnt_ctl_q[k][tmb_pkg::CNT_ENABLE] && !o_halt)
            cnt_q[k] <= cnt_q[k] + 16'h0001;
      end
      always_ff @(posedge i_clk or negedge i_resetn)
      begin
         if (!i_resetn)
            cnt_ctl_q[k] <= tmb_pkg::RST_WORD;
         else if (sm_wr && sm.idx == IV + 6'h01)
            cnt_ctl_q[k] <= merge(cnt_ctl_q[k], sm.wdata, sm.be)
               & tmb_pkg::CNT_CTL_MASK;
      end
   end

   // -----------------------------------------------------------------
   // time lanes: wired-OR of every counter, enabled or not
   // -----------------------------------------------------------------
   always_comb
   begin
      for (int l = 0; l < tmb_pkg::NUM_LANES; l++)
         lane_or[l] = '0;
      // counter 0 sits with low channels (lanes three/four)
      lane_or[cnt_ctl_q[0][tmb_pkg::LANE_SEL] ? 3 : 2] |= cnt_q[0];
      lane_or[cnt_ctl_q[1][tmb_pkg::LANE_SEL] ? 1 : 0] |= cnt_q[1];
   end

   always_comb
   begin
      for (int l = 0; l < tmb_pkg::NUM_LANES; l++)
         lane[l] = lane_or[l];
      if (JOIN_LANES)
      begin
         lane[0] = lane_or[0] | lane_or[3];
         lane[3] = lane[0];
         lane[1] = lane_or[1] | lane_or[2];
         lane[2] = lane[1];
      end
   end

   assign o_lanes = {lane[3], lane[2], lane[1], lane[0]};

   // -----------------------------------------------------------------
   // capture channels (readers of the lanes)
   // -----------------------------------------------------------------
   for (genvar c = 0; c < NUM_CH; c++)
   begin : g_ch
      localparam logic [5:0] IC = tmb_pkg::IDX_CH_BASE + 6'(2*c);
      localparam int BASE = (c + 1 < SPLIT_M) ? 2 : 0;
      logic clr;
      logic [W-1:0] nv;

      tmb_capture u_cap
      (
         .i_clk(i_clk),
         .i_resetn(i_resetn),
         .i_pin(i_cap_pin[c]),
         .i_rising(ch_ctl_q[c][tmb_pkg::CH_RISING]),
         .i_lane(lane[BASE + 32'(ch_ctl_q[c][tmb_pkg::LANE_SEL])]),
         .o_event(cap_evt[c]),
         .o_value_q(cap_val[c])
      );

      assign nv = merge(ch_ctl_q[c], sm.wdata, sm.be);
      // zero written to the flag, and only after a read saw it set
      assign clr = sm_wr && sm.idx == IC && sm.be[1] && armed_q[c]
         && !sm.wdata[tmb_pkg::CH_FLAG];

      always_ff @(posedge i_clk or negedge i_resetn)
      begin
         if (!i_resetn)
            ch_ctl_q[c] <= tmb_pkg::RST_WORD;
         else
         begin
            if (sm_wr && sm.idx == IC)
               ch_ctl_q[c][W-2:0] <= nv[W-2:0] & tmb_pkg::CH_CTL_MASK[W-2:0];
            // set wins over a clear in the same cycle
            if (cap_evt[c])
               ch_ctl_q[c][tmb_pkg::CH_FLAG] <= 1'b1;
            else if (clr)
               ch_ctl_q[c][tmb_pkg::CH_FLAG] <= 1'b0;
         end
      end

      // an event between read and write disarms the clear
      always_ff @(posedge i_clk or negedge i_resetn)
      begin
         if (!i_resetn)
            armed_q[c] <= 1'b0;
         else if (cap_evt[c] || (sm_wr && sm.idx == IC))
            armed_q[c] <= 1'b0;
         else if (sm_rd && sm.idx == IC && ch_ctl_q[c][tmb_pkg::CH_FLAG])
            armed_q[c] <= 1'b1;
      end

      assign o_irq_req[c] = ch_ctl_q[c][tmb_pkg::CH_FLAG]
         && ch_ctl_q[c][tmb_pkg::CH_IRQ_EN];
   end

   // -----------------------------------------------------------------
   // read path
   // -----------------------------------------------------------------
   always_comb
   begin
      rd_word = '0;
      if (sm.idx == tmb_pkg::IDX_MCR)
         rd_word = mcr_q;
      for (int k = 0; k < 2; k++)
      begin
         if (sm.idx == tmb_pkg::IDX_CNT_BASE + 6'(2*k))
            rd_word = cnt_q[k];
         if (sm.idx == tmb_pkg::IDX_CNT_BASE + 6'(2*k+1))
            rd_word = cnt_ctl_q[k];
      end
      for (int c = 0; c < NUM_CH; c++)
      begin
         if (sm.idx == tmb_pkg::IDX_CH_BASE + 6'(2*c))
            rd_word = ch_ctl_q[c];
         if (sm.idx == tmb_pkg::IDX_CH_BASE + 6'(2*c+1))
            rd_word = cap_val[c];
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         o_rdata <= '0;
      else if (take)
         o_rdata <= '0;
      else if (sm_rd && is_byte)
         o_rdata[7:0] <= req_q.addr[0] ? rd_word[7:0] : rd_word[15:8];
      else if (sm_rd && sm.long_ind)
         o_rdata[31:16] <= rd_word;
      else if (sm_rd)
         o_rdata[15:0] <= rd_word;
   end

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   sequence s_take_short;
      take && !(i_host.size == tmb_pkg::SZ_LONG && !i_host.addr[0]);
   endsequence
   sequence s_take_long;
      take && i_host.size == tmb_pkg::SZ_LONG && !i_host.addr[0];
   endsequence

   a_short_ack: assert property (@(posedge i_clk) disable iff (!i_resetn)
      s_take_short |-> ##1 !o_ack ##1 o_ack)
      else $error("single access not acknowledged after two cycles");
   a_long_split: assert property (@(posedge i_clk) disable iff (!i_resetn)
      s_take_long |=> sm.long_ind && sm.act ##1 !sm.long_ind && sm.act
      ##1 o_ack)
      else $error("long word not split into two words");
   a_odd_byte: assert property (@(posedge i_clk) disable iff (!i_resetn)
      sm.act && req_q.addr[0] |-> sm.be == 2'h1 && !sm.long_ind)
      else $error("odd access not a single low byte");
   a_even_byte: assert property (@(posedge i_clk) disable iff (!i_resetn)
      sm.act && req_q.size == tmb_pkg::SZ_BYTE && !req_q.addr[0]
      |-> sm.be == 2'h2)
      else $error("even byte not on high lane");
   a_triple_word: assert property (@(posedge i_clk) disable iff (!i_resetn)
      sm.act && req_q.size == tmb_pkg::SZ_TRIPLE && !req_q.addr[0]
      |-> sm.be == 2'h3 ##1 o_ack)
      else $error("three-byte not a single word");
   a_halt_pass: assert property (@(posedge i_clk) disable iff (!i_resetn)
      o_halt == ($past(i_halt) && $past(mcr_q[tmb_pkg::MCR_HALT_PASS])))
      else $error("halt forwarding wrong");
   a_flag_set: assert property (@(posedge i_clk) disable iff (!i_resetn)
      cap_evt[0] |=> ch_ctl_q[0][tmb_pkg::CH_FLAG] && !armed_q[0])
      else $error("capture flag not set");
   a_flag_keep: assert property (@(posedge i_clk) disable iff (!i_resetn)
      ch_ctl_q[0][tmb_pkg::CH_FLAG] && !armed_q[0]
      |=> ch_ctl_q[0][tmb_pkg::CH_FLAG])
      else $error("flag cleared without prior read");
   a_reserved_zero: assert property (@(posedge i_clk) disable iff (!i_resetn)
      sm_rd && sm.idx == 6'h01 |-> rd_word == 16'h0000)
      else $error("reserved location not zero");
endmodule : tmb_bridge
`default_nettype wire

// ===== rtl/tmb_capture.sv
`default_nettype none
module tmb_capture
(
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_pin,
   input wire logic i_rising,
   input wire logic [tmb_pkg::DATA_W-1:0] i_lane,
   output logic o_event,
   output logic [tmb_pkg::DATA_W-1:0] o_value_q
);
   // -----------------------------------------------------------------
   // pin synchroniser
   // -----------------------------------------------------------------
   logic [tmb_pkg::SYNC_STAGES-1:0] sync_q;
   logic level_q;

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         sync_q <= '0;
      else
         sync_q <= {sync_q[1:0], i_pin};
   end

   // a change counts only once stages two and three agree
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         level_q <= 1'b0;
      else if (sync_q[1] == sync_q[2])
         level_q <= sync_q[2];
   end

   // -----------------------------------------------------------------
   // edge select and capture
   // -----------------------------------------------------------------
   assign o_event = (sync_q[1] == sync_q[2]) && (sync_q[2] != level_q)
      && (sync_q[2] == i_rising);

   // later events overwrite an unread stamp
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         o_value_q <= tmb_pkg::RST_WORD;
      else if (o_event)
         o_value_q <= i_lane;
   end

   a_capture_value: assert property (@(posedge i_clk) disable iff (!i_resetn)
      o_event |=> o_value_q == $past(i_lane))
      else $error("capture did not latch lane value");
   a_capture_edge: assert property (@(posedge i_clk) disable iff (!i_resetn)
      o_event |-> sync_q[2] == i_rising && level_q != i_rising)
      else $error("capture on wrong edge");
endmodule : tmb_capture
`default_nettype wire

// ===== rtl/tmb_pkg.sv
`default_nettype none
package tmb_pkg;
   // -----------------------------------------------------------------
   // host transfer encoding
   // -----------------------------------------------------------------
   localparam int ADDR_W = 7;
   localparam int IDX_W = 6;
   localparam int DATA_W = 16;
   typedef enum logic [1:0]
   {
      SZ_BYTE = 2'h0,
      SZ_WORD = 2'h1,
      SZ_TRIPLE = 2'h2,
      SZ_LONG = 2'h3
   } tmb_size_type;
   typedef struct packed
   {
      logic wr;
      tmb_size_type size;
      logic [ADDR_W-1:0] addr;
      logic [31:0] wdata;
   } tmb_host_req_type;
   typedef struct packed
   {
      logic act;
      logic wr;
      logic long_ind;
      logic [1:0] be;
      logic [IDX_W-1:0] idx;
      logic [DATA_W-1:0] wdata;
   } tmb_sm_bus_type;
   // -----------------------------------------------------------------
   // bridge states, gray along the long-word path; a short access goes HIGH to DONE, two bits
   // -----------------------------------------------------------------
   typedef enum logic [1:0]
   {
      ST_IDLE = 2'h0,
      ST_HIGH = 2'h1,
      ST_LOW = 2'h3,
      ST_DONE = 2'h2
   } tmb_state_type;
   // -----------------------------------------------------------------
   // register word indexes and fields
   // -----------------------------------------------------------------
   localparam logic [IDX_W-1:0] IDX_MCR = 6'h00;
   localparam logic [IDX_W-1:0] IDX_CNT_BASE = 6'h04;
   localparam logic [IDX_W-1:0] IDX_CH_BASE = 6'h08;
   localparam int MCR_HALT_PASS = 0;
   localparam int CNT_ENABLE = 0;
   localparam int LANE_SEL = 1;
   localparam int CH_RISING = 0;
   localparam int CH_IRQ_EN = 2;
   localparam int CH_FLAG = 15;
   localparam logic [DATA_W-1:0] RST_WORD = 16'h0000;
   localparam logic [DATA_W-1:0] CNT_CTL_MASK = 16'h0003;
   localparam logic [DATA_W-1:0] CH_CTL_MASK = 16'h0007;
   localparam int NUM_LANES = 4;
   localparam int SYNC_STAGES = 3;
endpackage : tmb_pkg
`default_nettype wire
